// >>> hdl/safety_monitor.sv
// Safety diagnostic monitors: clocks, ground loss, temperature, spreading
// Contract
// - Loop enable inputs pass a deglitch filter of about 10 us.
// - Phase drive outputs can go high impedance, both sources off.
// - System clock nominal 40 MHz, triangular modulation when spreading; the code assumes 25 MHz (CLK_MHZ).
// - Spreading range 1.5 to 3 percent, modulation 9.7 to 39 kHz.
// - Spread enable bit: 0 off at reset, 1 on.
// - With spreading, internal delays and filters vary by the spread.
// - Without oscillator, bus keeps returning its latest response.
// - Two oscillators: main runs logic, auxiliary feeds only monitoring; the code runs on REF_CLK and only measures both.
// - Two chains: main measured against aux, aux against main.
// - Deviation of 25 percent sets mismatch; aux-relative one resets too.
// - Main period at 14 us sets reset and main stuck flags, resets.
// - Aux period timeout sets only the aux stuck flag.
// - Any clock mismatch or timeout forces the safe state.
// - Clock flags hold until failure gone and bus or pin clear.
// - A self-check verifies the clock monitor logic.
// - Ground-lost flags set after offset persists beyond 1.25 ms.
// - The ground loss detector has a self-check too.
// - 8-bit temperature code readable; Tj = 1.378*code - 66.52.
// - Warning and shutdown comparators with about 10 degree hysteresis.
// - Warning flag sets after filter time, clears when condition gone.
// - Shutdown at 175 degrees: flag, high-z, cleared by enable rise.
// - Warning select 00..11 picks 130, 140 default, 150, 160 degrees.
//
// Implementation choices: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/100ps
module safety_monitor
#(
  parameter int GND_FILT = safety_pkg::GND_FILT_CYC,
  parameter int WARN_FILT = safety_pkg::WARN_FILT_SAMPLES,
  parameter int SD_FILT = safety_pkg::SD_FILT_SAMPLES
)
(
  input wire logic REF_CLK,
  input wire logic NRST,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [7:0] AWADDR,
  input wire logic WVALID,
  output logic WREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  output logic BVALID,
  input wire logic BREADY,
  output logic [1:0] BRESP,
  input wire logic ARVALID,
  output logic ARREADY,
  input wire logic [7:0] ARADDR,
  output logic RVALID,
  input wire logic RREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  input wire logic [1:0] LOOP_ENABLE_PIN,
  input wire logic MAIN_OSC,
  input wire logic AUX_OSC,
  input wire logic DGND_HIGH,
  input wire logic AGND_HIGH,
  input wire logic [7:0] TEMP_CODE,
  input wire logic TEMP_VALID,
  input wire logic [7:0] PHASE_DRIVE_IN,
  output logic [7:0] PHASE_DRIVE_OUT,
  output logic [7:0] PHASE_DRIVE_OE,
  output logic [3:0] SPREAD_TRIM,
  output logic SAFE_STATE,
  output logic INT_RESET
);
  import safety_pkg::*;

  typedef struct packed
  {
    logic spread_en;
    logic [1:0] warn_sel;
    logic aw_got;
    logic w_got;
    logic [7:0] waddr;
    logic [31:0] wdata;
    logic wstrb0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic main_q;
    logic aux_q;
    logic [8:0] main_cnt;
    logic [8:0] aux_cnt;
    logic [8:0] main_per;
    logic [8:0] aux_per;
    logic mismatch;
    logic int_rst_flag;
    logic main_stuck;
    logic aux_stuck;
    logic dgnd;
    logic agnd;
    logic warn;
    logic sd;
    logic selftest_ok;
    logic rst_cond;
    logic int_reset;
    logic safe;
    logic [1:0] en_q;
    logic [7:0] code;
    logic warn_cmp;
    logic sd_cmp;
    logic [7:0] warn_cnt;
    logic [7:0] sd_cnt;
    logic [5:0] div_cnt;
    logic [3:0] tri_lvl;
    logic tri_up;
    logic [3:0] trim;
    logic [7:0] phase_out;
    logic [7:0] phase_oe;
  } state_s;
  state_s s;
  state_s next_s;

  // ---------------------------------------------
  // Helpers
  // ---------------------------------------------
  // Deviation of x/y from one by 25 percent or more
  function automatic logic dev_hit(input logic [8:0] x, input logic [8:0] y);
    logic [11:0] x4;
    logic [11:0] y5;
    logic [11:0] y3;
    x4 = {1'b0, x, 2'b00};
    y5 = {3'b000, y} + {1'b0, y, 2'b00};
    y3 = {3'b000, y} + {2'b00, y, 1'b0};
    return (x4 >= y5) || (x4 <= y3);
  endfunction

  function automatic logic [7:0] warn_code(input logic [1:0] sel);
    logic [7:0] c;
    unique case (sel)
      2'b00: c = WARN_CODE_130;
      2'b01: c = WARN_CODE_140;
      2'b10: c = WARN_CODE_150;
      2'b11: c = WARN_CODE_160;
    endcase
    return c;
  endfunction

  // Hysteresis comparator: trips at th, releases below th - HYST_CODE
  function automatic logic hyst_cmp(input logic on, input logic [7:0] code,
    input logic [7:0] th);
    return on ? (code >= th - HYST_CODE) : (code >= th);
  endfunction

  // ---------------------------------------------
  // Input filters
  // ---------------------------------------------
  // Filter times scale with the clock, so spreading jitters them alike
  logic [1:0] en_filt;
  logic dgnd_filt;
  logic agnd_filt;
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_en
      persist_filter #(.CYCLES(DEGLITCH_CYC)) u_en_filt (
        .clk(REF_CLK),
        .rst_n(NRST),
        .level(LOOP_ENABLE_PIN[gi]),
        .filtered(en_filt[gi])
      );
    end
  endgenerate
  persist_filter #(.CYCLES(GND_FILT)) u_dgnd_filt (
    .clk(REF_CLK),
    .rst_n(NRST),
    .level(DGND_HIGH),
    .filtered(dgnd_filt)
  );
  persist_filter #(.CYCLES(GND_FILT)) u_agnd_filt (
    .clk(REF_CLK),
    .rst_n(NRST),
    .level(AGND_HIGH),
    .filtered(agnd_filt)
  );

  // ---------------------------------------------
  // Combinational next state
  // ---------------------------------------------
  logic main_rise;
  logic aux_rise;
  logic mis1;
  logic mis2;
  logic main_to;
  logic aux_to;
  logic en_rise;
  logic wr_go;
  logic bus_clr;
  logic clr;
  logic [31:0] status;

  always_comb
  begin
    next_s = s;
    // REF_CLK runs the system; main and aux oscillators are both only sampled and measured
    main_rise = MAIN_OSC && !s.main_q;
    aux_rise = AUX_OSC && !s.aux_q;
    main_to = s.main_cnt == 9'(STUCK_CYC);
    aux_to = s.aux_cnt == 9'(STUCK_CYC);
    // Chain one: aux against main; chain two: main against aux
    mis1 = (s.main_per != '0) && (s.aux_per != '0) && dev_hit(s.aux_per, s.main_per);
    mis2 = (s.main_per != '0) && (s.aux_per != '0) && dev_hit(s.main_per, s.aux_per);
    en_rise = |(en_filt & ~s.en_q);
    status = '0;
    status[STAT_MISMATCH] = s.mismatch;
    status[STAT_INT_RST] = s.int_rst_flag;
    status[STAT_MAIN_STUCK] = s.main_stuck;
    status[STAT_AUX_STUCK] = s.aux_stuck;
    status[STAT_DGND] = s.dgnd;
    status[STAT_AGND] = s.agnd;
    status[STAT_WARN] = s.warn;
    status[STAT_SHUTDOWN] = s.sd;
    status[STAT_SAFE] = s.safe;
    status[STAT_SELFTEST_OK] = s.selftest_ok;

    // AXI4-Lite write: address and data in either order
    if (AWVALID && !s.aw_got)
    begin
      next_s.aw_got = 1'b1;
      next_s.waddr = AWADDR;
    end
    if (WVALID && !s.w_got)
    begin
      next_s.w_got = 1'b1;
      next_s.wdata = WDATA;
      next_s.wstrb0 = WSTRB[0];
    end
    wr_go = s.aw_got && s.w_got && !s.bvalid;
    bus_clr = 1'b0;
    if (wr_go)
    begin
      next_s.aw_got = 1'b0;
      next_s.w_got = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = RESP_OKAY;
      unique case (s.waddr)
        CTRL_ADDR:
        begin
          if (s.wstrb0)
          begin
            next_s.spread_en = s.wdata[CTRL_SPREAD_BIT];
            next_s.warn_sel = {s.wdata[CTRL_WARN_HI_BIT], s.wdata[CTRL_WARN_LO_BIT]};
            if (s.wdata[CTRL_SELFTEST_BIT])
            begin
              // Known-good and known-bad periods through the same comparator
              next_s.selftest_ok = dev_hit(9'h010, 9'h008) && !dev_hit(9'h008, 9'h008)
                && !(DGND_HIGH && AGND_HIGH);
            end
          end
        end
        CLEAR_ADDR: bus_clr = s.wstrb0 && s.wdata[0];
        STATUS_ADDR, TEMP_ADDR: ;
        default: next_s.bresp = RESP_DECERR;
      endcase
    end
    if (s.bvalid && BREADY)
      next_s.bvalid = 1'b0;

    // AXI4-Lite read; data stays put between answers
    if (ARVALID && !s.rvalid)
    begin
      next_s.rvalid = 1'b1;
      next_s.rresp = RESP_OKAY;
      unique case (ARADDR)
        CTRL_ADDR: next_s.rdata = {29'h0, s.warn_sel, s.spread_en};
        STATUS_ADDR: next_s.rdata = status;
        CLEAR_ADDR: next_s.rdata = '0;
        TEMP_ADDR: next_s.rdata = {24'h0, s.code};
        default:
        begin
          next_s.rdata = '0;
          next_s.rresp = RESP_DECERR;
        end
      endcase
    end
    if (s.rvalid && RREADY)
      next_s.rvalid = 1'b0;

    // Oscillator period measurement in REF_CLK cycles
    next_s.main_q = MAIN_OSC;
    next_s.aux_q = AUX_OSC;
    if (main_rise)
    begin
      next_s.main_per = s.main_cnt;
      next_s.main_cnt = 9'h001;
    end
    else if (!main_to)
      next_s.main_cnt = s.main_cnt + 9'h001;
    if (aux_rise)
    begin
      next_s.aux_per = s.aux_cnt;
      next_s.aux_cnt = 9'h001;
    end
    else if (!aux_to)
      next_s.aux_cnt = s.aux_cnt + 9'h001;

    // Flags: set wins over clear, clear only once the cause is gone
    clr = bus_clr || en_rise;
    next_s.en_q = en_filt;
    if (clr && !(mis1 || mis2))
      next_s.mismatch = 1'b0;
    if (clr && !main_to)
    begin
      next_s.main_stuck = 1'b0;
      next_s.int_rst_flag = 1'b0;
    end
    if (clr && !aux_to)
      next_s.aux_stuck = 1'b0;
    if (clr && !dgnd_filt)
      next_s.dgnd = 1'b0;
    if (clr && !agnd_filt)
      next_s.agnd = 1'b0;
    if (mis1 || mis2)
      next_s.mismatch = 1'b1;
    if (main_to)
    begin
      next_s.main_stuck = 1'b1;
      next_s.int_rst_flag = 1'b1;
    end
    if (aux_to)
      next_s.aux_stuck = 1'b1;
    if (dgnd_filt)
      next_s.dgnd = 1'b1;
    if (agnd_filt)
      next_s.agnd = 1'b1;
    // Reset pulse only from aux-relative deviation or main timeout
    next_s.rst_cond = mis1 || main_to;
    next_s.int_reset = (mis1 || main_to) && !s.rst_cond;

    // Temperature: sample on each conversion, filter in samples
    if (TEMP_VALID)
    begin
      next_s.code = TEMP_CODE;
      next_s.warn_cmp = hyst_cmp(s.warn_cmp, TEMP_CODE, warn_code(s.warn_sel));
      next_s.sd_cmp = hyst_cmp(s.sd_cmp, TEMP_CODE, SD_CODE_175);
      if (!next_s.warn_cmp)
        next_s.warn_cnt = '0;
      else if (s.warn_cnt != 8'(WARN_FILT))
        next_s.warn_cnt = s.warn_cnt + 8'h01;
      if (!next_s.sd_cmp)
        next_s.sd_cnt = '0;
      else if (s.sd_cnt != 8'(SD_FILT))
        next_s.sd_cnt = s.sd_cnt + 8'h01;
    end
    next_s.warn = next_s.warn_cmp && (s.warn || next_s.warn_cnt == 8'(WARN_FILT));
    if (!next_s.sd_cmp && en_rise)
      next_s.sd = 1'b0;
    if (next_s.sd_cmp && next_s.sd_cnt == 8'(SD_FILT))
      next_s.sd = 1'b1;

    // Safe state turns all phase drives to high impedance
    next_s.safe = next_s.mismatch || next_s.main_stuck || next_s.aux_stuck
      || next_s.sd;
    next_s.phase_out = next_s.safe ? 8'h00 : PHASE_DRIVE_IN;
    next_s.phase_oe = next_s.safe ? 8'h00 : 8'hFF;

    // Triangular trim for the oscillator around its 25 MHz carrier
    if (s.div_cnt == 6'(SPREAD_DIV - 1))
    begin
      next_s.div_cnt = '0;
      if (s.tri_up && s.tri_lvl == 4'(SPREAD_STEPS))
        next_s.tri_up = 1'b0;
      else if (!s.tri_up && s.tri_lvl == 4'h0)
        next_s.tri_up = 1'b1;
      else
        next_s.tri_lvl = s.tri_up ? s.tri_lvl + 4'h1 : s.tri_lvl - 4'h1;
    end
    else
      next_s.div_cnt = s.div_cnt + 6'h01;
    next_s.trim = s.spread_en ? s.tri_lvl : 4'h0;
  end

  // ---------------------------------------------
  // State register
  // ---------------------------------------------
  always_ff @(posedge REF_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      s <= '0;
      s.spread_en <= CTRL_SPREAD_RST;
      s.warn_sel <= CTRL_WARN_RST;
      s.tri_up <= 1'b1;
    end
    else
      s <= next_s;
  end

  assign AWREADY = !s.aw_got;
  assign WREADY = !s.w_got;
  assign BVALID = s.bvalid;
  assign BRESP = s.bresp;
  assign ARREADY = !s.rvalid;
  assign RVALID = s.rvalid;
  assign RDATA = s.rdata;
  assign RRESP = s.rresp;
  assign PHASE_DRIVE_OUT = s.phase_out;
  assign PHASE_DRIVE_OE = s.phase_oe;
  assign SPREAD_TRIM = s.trim;
  assign SAFE_STATE = s.safe;
  assign INT_RESET = s.int_reset;

  // ---------------------------------------------
  // Assertions
  // ---------------------------------------------
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!NRST);

  spread_off_a: assert property (!s.spread_en |=> SPREAD_TRIM == 4'h0)
    else $error("trim moves with spreading off");
  main_stuck_a: assert property (main_to |=> s.main_stuck && s.int_rst_flag)
    else $error("main timeout not flagged");
  aux_stuck_a: assert property (aux_to && !main_to && !s.rst_cond && !mis1
    |=> s.aux_stuck && !INT_RESET)
    else $error("aux timeout wrong reaction");
  hiz_safe_a: assert property (SAFE_STATE |-> PHASE_DRIVE_OE == 8'h00)
    else $error("phase drive active in safe state");
  flag_hold_a: assert property (s.mismatch && !clr |=> s.mismatch)
    else $error("mismatch flag dropped without clear");
  sd_hold_a: assert property (s.sd && !en_rise |=> s.sd)
    else $error("shutdown flag dropped without enable rise");
  warn_cond_a: assert property (s.warn |-> s.warn_cmp && s.warn_cnt == 8'(WARN_FILT))
    else $error("warning held without condition");
  rdata_hold_a: assert property (!(ARVALID && ARREADY) |=> $stable(RDATA))
    else $error("read data changed without request");
  mis_reset_a: assert property ($rose(mis1) && !s.rst_cond |=> INT_RESET)
    else $error("aux-relative mismatch gave no reset");
  safe_enter_a: assert property (s.mismatch |-> SAFE_STATE)
    else $error("mismatch without safe state");

  wr_cov: cover property (BVALID && BREADY);
  sd_cov: cover property ($rose(s.sd));
  clr_cov: cover property ($fell(s.mismatch));
endmodule

// >>> hdl/safety_pkg.sv
// Constants shared by the safety diagnostic monitor files
package safety_pkg;
  // ---------------------------------------------
  // Clock and timing
  // ---------------------------------------------
  localparam int CLK_MHZ = 25;
  localparam int DEGLITCH_NS = 10000;
  localparam int DEGLITCH_CYC = DEGLITCH_NS * CLK_MHZ / 1000;
  localparam int STUCK_TIMEOUT_NS = 14000;
  localparam int STUCK_CYC = STUCK_TIMEOUT_NS * CLK_MHZ / 1000;
  localparam int GND_FILT_US = 1250;
  localparam int GND_FILT_CYC = GND_FILT_US * CLK_MHZ;
  localparam int WARN_FILT_SAMPLES = 4;
  localparam int SD_FILT_SAMPLES = 4;
  // Spreading: triangle of 15 trim steps each way over levels 0 to 15, one step per divider pulse except the turnaround pulse at each end
  localparam int SPREAD_DIV = 40;
  localparam int SPREAD_STEPS = 15;
  // ---------------------------------------------
  // Register map (byte addresses)
  // ---------------------------------------------
  localparam logic [7:0] CTRL_ADDR = 8'h00;
  localparam logic [7:0] STATUS_ADDR = 8'h04;
  localparam logic [7:0] CLEAR_ADDR = 8'h08;
  localparam logic [7:0] TEMP_ADDR = 8'h0C;
  localparam int CTRL_SPREAD_BIT = 0;
  localparam int CTRL_WARN_LO_BIT = 1;
  localparam int CTRL_WARN_HI_BIT = 2;
  localparam int CTRL_SELFTEST_BIT = 3;
  localparam logic CTRL_SPREAD_RST = 1'b0;
  localparam logic [1:0] CTRL_WARN_RST = 2'b01;
  localparam int STAT_MISMATCH = 0;
  localparam int STAT_INT_RST = 1;
  localparam int STAT_MAIN_STUCK = 2;
  localparam int STAT_AUX_STUCK = 3;
  localparam int STAT_DGND = 4;
  localparam int STAT_AGND = 5;
  localparam int STAT_WARN = 6;
  localparam int STAT_SHUTDOWN = 7;
  localparam int STAT_SAFE = 8;
  localparam int STAT_SELFTEST_OK = 9;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_DECERR = 2'b11;
  // ---------------------------------------------
  // Temperature codes: code = ceil((degC + 66.52) / 1.378)
  // ---------------------------------------------
  localparam logic [7:0] WARN_CODE_130 = 8'h8F;
  localparam logic [7:0] WARN_CODE_140 = 8'h96;
  localparam logic [7:0] WARN_CODE_150 = 8'h9E;
  localparam logic [7:0] WARN_CODE_160 = 8'hA5;
  localparam logic [7:0] SD_CODE_175 = 8'hB0;
  localparam logic [7:0] HYST_CODE = 8'h07;
endpackage

// >>> hdl/persist_filter.sv
// Persistence filter: output follows input after a stable run of CYCLES
`timescale 1ns/100ps
module persist_filter
#(
  parameter int CYCLES = 250
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic level,
  output logic filtered
);
  localparam int CW = $clog2(CYCLES + 1);
  typedef struct packed
  {
    logic [CW-1:0] cnt;
    logic out;
  } filt_s;
  filt_s s;
  filt_s next_s;

  always_comb
  begin
    next_s = s;
    if (level == s.out)
    begin
      next_s.cnt = '0;
    end
    else if (s.cnt == CW'(CYCLES - 1))
    begin
      next_s.out = level;
      next_s.cnt = '0;
    end
    else
    begin
      next_s.cnt = s.cnt + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      s <= '0;
    else
      s <= next_s;
  end

  assign filtered = s.out;
endmodule

// >>> tb/far_side_model.sv
// Far-side model: both oscillators and the loop enable pin drivers
`timescale 1ns/100ps
module far_side_model
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] main_half,
  input wire logic [7:0] aux_half,
  input wire logic main_run,
  input wire logic aux_run,
  input wire logic [1:0] clear_req,
  output logic main_osc,
  output logic aux_osc,
  output logic [1:0] enable_pin
);
  // Low time of a pin clear, well beyond the deglitch span
  localparam int CLEAR_LOW = 300;
  logic [7:0] main_cnt;
  logic [7:0] aux_cnt;
  logic [8:0] low_cnt [2];
  assign enable_pin = {low_cnt[1] == 9'h000, low_cnt[0] == 9'h000};
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      main_cnt <= 8'h00;
      aux_cnt <= 8'h00;
      main_osc <= 1'b0;
      aux_osc <= 1'b0;
      low_cnt[0] <= 9'h000;
      low_cnt[1] <= 9'h000;
    end
    else
    begin
      main_cnt <= (main_cnt + 8'h01 >= main_half) ? 8'h00 : main_cnt + 8'h01;
      aux_cnt <= (aux_cnt + 8'h01 >= aux_half) ? 8'h00 : aux_cnt + 8'h01;
      // A stopped oscillator freezes at its level
      if (main_cnt + 8'h01 >= main_half && main_run)
        main_osc <= ~main_osc;
      if (aux_cnt + 8'h01 >= aux_half && aux_run)
        aux_osc <= ~aux_osc;
      for (int i = 0; i < 2; i++)
      begin
        if (clear_req[i] && low_cnt[i] == 9'h000)
          low_cnt[i] <= 9'(CLEAR_LOW);
        else if (low_cnt[i] != 9'h000)
          low_cnt[i] <= low_cnt[i] - 9'h001;
      end
    end
  end
endmodule

// >>> tb/testbench.sv
// Self-checking bench for the safety diagnostic monitor
`timescale 1ns/100ps
module testbench;
  import safety_pkg::*;
  logic ref_clk, nrst, awvalid, wvalid, bready, arvalid, rready, temp_valid;
  logic awready, wready, bvalid, arready, rvalid, main_osc, aux_osc;
  logic safe_state, int_reset, main_run, aux_run;
  logic [7:0] awaddr, araddr, temp_code, phase_in, phase_out, phase_oe, main_half, aux_half;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb, spread_trim;
  logic [1:0] bresp, rresp, clear_req, enable_pin, gnd;
  logic [7:0] th [4];
  int n_fail, num_checks, n_irst, k;

  safety_monitor #(.GND_FILT(20), .WARN_FILT(2), .SD_FILT(2)) dut (.REF_CLK(ref_clk),
    .NRST(nrst), .AWVALID(awvalid), .AWREADY(awready), .AWADDR(awaddr), .WVALID(wvalid),
    .WREADY(wready), .WDATA(wdata), .WSTRB(wstrb), .BVALID(bvalid), .BREADY(bready),
    .BRESP(bresp), .ARVALID(arvalid), .ARREADY(arready), .ARADDR(araddr), .RVALID(rvalid),
    .RREADY(rready), .RDATA(rdata), .RRESP(rresp), .LOOP_ENABLE_PIN(enable_pin),
    .MAIN_OSC(main_osc), .AUX_OSC(aux_osc), .DGND_HIGH(gnd[0]), .AGND_HIGH(gnd[1]),
    .TEMP_CODE(temp_code), .TEMP_VALID(temp_valid), .PHASE_DRIVE_IN(phase_in),
    .PHASE_DRIVE_OUT(phase_out), .PHASE_DRIVE_OE(phase_oe), .SPREAD_TRIM(spread_trim),
    .SAFE_STATE(safe_state), .INT_RESET(int_reset));

  far_side_model partner (.clk(ref_clk), .rst_n(nrst), .main_half(main_half),
    .aux_half(aux_half), .main_run(main_run), .aux_run(aux_run), .clear_req(clear_req),
    .main_osc(main_osc), .aux_osc(aux_osc), .enable_pin(enable_pin));

  initial
  begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk)
    if (int_reset === 1'b1)
      n_irst <= n_irst + 1;

  // ---------------------------------------------
  // Bus and stimulus tasks
  // ---------------------------------------------
  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    bit aw_done;
    bit w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge ref_clk);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    bready <= 1'b1;
    while (!(aw_done && w_done))
    begin
      @(posedge ref_clk);
      if (awready === 1'b1)
        aw_done = 1'b1;
      if (wready === 1'b1)
        w_done = 1'b1;
      if (aw_done)
        awvalid <= 1'b0;
      if (w_done)
        wvalid <= 1'b0;
    end
    do @(posedge ref_clk); while (bvalid !== 1'b1);
    bready <= 1'b0;
    check("write response", 32'(bresp), 32'(er));
  endtask

  task rd(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp,
    input logic [1:0] er);
    @(posedge ref_clk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do @(posedge ref_clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge ref_clk); while (rvalid !== 1'b1);
    rready <= 1'b0;
    check("read data", rdata & mask, exp);
    check("read response", 32'(rresp), 32'(er));
  endtask

  task temp(input logic [7:0] c, input int n);
    repeat (n)
    begin
      @(posedge ref_clk);
      temp_code <= c;
      temp_valid <= 1'b1;
      @(posedge ref_clk);
      temp_valid <= 1'b0;
      repeat (3) @(posedge ref_clk);
    end
  endtask

  task pin_clear;
    @(posedge ref_clk);
    clear_req <= 2'b01;
    @(posedge ref_clk);
    clear_req <= 2'b00;
    repeat (650) @(posedge ref_clk);
  endtask

  task report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial
  begin
    #(40 * 60000);
    n_fail++;
    report_and_stop;
  end

  // ---------------------------------------------
  // Test sequence
  // ---------------------------------------------
  initial
  begin
    {n_fail, num_checks, n_irst} = '0;
    {nrst, awvalid, wvalid, bready, arvalid, rready, temp_valid} = '0;
    {awaddr, araddr, temp_code, wdata, clear_req, gnd} = '0;
    {main_run, aux_run} = 2'b11;
    main_half = 8'h0A;
    aux_half = 8'h0A;
    phase_in = 8'h5A;
    wstrb = 4'hF;
    th = '{WARN_CODE_130, WARN_CODE_140, WARN_CODE_150, WARN_CODE_160};
    repeat (5) @(posedge ref_clk);
    nrst <= 1'b1;
    repeat (300) @(posedge ref_clk);
    rd(CTRL_ADDR, 32'h0000000F, 32'h00000002, RESP_OKAY);
    rd(STATUS_ADDR, 32'h000001FF, 32'h00000000, RESP_OKAY);
    rd(8'h10, 32'h00000000, 32'h00000000, RESP_DECERR);
    wr(8'h14, 32'h00000001, RESP_DECERR);
    check("drive out", 32'(phase_out), 32'h0000005A);
    check("drive enable", 32'(phase_oe), 32'h000000FF);
    check("trim off", 32'(spread_trim), 32'h00000000);
    wr(CTRL_ADDR, 32'h00000003, RESP_OKAY);
    k = 0;
    repeat (200)
    begin
      @(posedge ref_clk);
      k = k | 32'(spread_trim);
    end
    check("trim moving", 32'(k != 0), 32'h00000001);
    rd(CTRL_ADDR, 32'h0000000F, 32'h00000003, RESP_OKAY);
    wr(CTRL_ADDR, 32'h0000000A, RESP_OKAY);
    repeat (100) @(posedge ref_clk);
    check("trim off", 32'(spread_trim), 32'h00000000);
    rd(STATUS_ADDR, 32'h00000200, 32'h00000200, RESP_OKAY);
    rd(CTRL_ADDR, 32'h0000000F, 32'h00000002, RESP_OKAY);
    for (int i = 0; i < 2; i++)
    begin
      gnd <= 2'b01 << i;
      repeat (10) @(posedge ref_clk);
      gnd <= 2'b00;
      rd(STATUS_ADDR, 32'h00000030, 32'h00000000, RESP_OKAY);
      gnd <= 2'b01 << i;
      repeat (30) @(posedge ref_clk);
      gnd <= 2'b00;
      rd(STATUS_ADDR, 32'h00000030, 32'h00000010 << i, RESP_OKAY);
      repeat (30) @(posedge ref_clk);
      wr(CLEAR_ADDR, 32'h00000001, RESP_OKAY);
      rd(STATUS_ADDR, 32'h00000030, 32'h00000000, RESP_OKAY);
    end
    for (int s = 0; s < 4; s++)
    begin
      wr(CTRL_ADDR, 32'(s) << 1, RESP_OKAY);
      temp(th[s] - 8'h01, 3);
      temp(th[s], 1);
      rd(STATUS_ADDR, 32'h00000040, 32'h00000000, RESP_OKAY);
      temp(th[s], 1);
      rd(STATUS_ADDR, 32'h00000040, 32'h00000040, RESP_OKAY);
      temp(th[s] - HYST_CODE, 2);
      rd(STATUS_ADDR, 32'h00000040, 32'h00000040, RESP_OKAY);
      temp(th[s] - HYST_CODE - 8'h01, 2);
      rd(STATUS_ADDR, 32'h00000040, 32'h00000000, RESP_OKAY);
      rd(TEMP_ADDR, 32'h000000FF, 32'(th[s] - HYST_CODE - 8'h01), RESP_OKAY);
    end
    temp(SD_CODE_175, 3);
    rd(STATUS_ADDR, 32'h00000180, 32'h00000180, RESP_OKAY);
    check("drive enable", 32'(phase_oe), 32'h00000000);
    check("drive out", 32'(phase_out), 32'h00000000);
    temp(8'h50, 3);
    wr(CLEAR_ADDR, 32'h00000001, RESP_OKAY);
    rd(STATUS_ADDR, 32'h00000080, 32'h00000080, RESP_OKAY);
    pin_clear;
    rd(STATUS_ADDR, 32'h00000180, 32'h00000000, RESP_OKAY);
    check("drive enable", 32'(phase_oe), 32'h000000FF);
    k = n_irst;
    aux_run <= 1'b0;
    repeat (400) @(posedge ref_clk);
    rd(STATUS_ADDR, 32'h0000010E, 32'h00000108, RESP_OKAY);
    check("reset pulses", 32'(n_irst - k), 32'h00000000);
    wr(CLEAR_ADDR, 32'h00000001, RESP_OKAY);
    rd(STATUS_ADDR, 32'h00000008, 32'h00000008, RESP_OKAY);
    aux_run <= 1'b1;
    repeat (200) @(posedge ref_clk);
    wr(CLEAR_ADDR, 32'h00000001, RESP_OKAY);
    rd(STATUS_ADDR, 32'h0000010F, 32'h00000000, RESP_OKAY);
    k = n_irst;
    main_half <= 8'h0D;
    repeat (300) @(posedge ref_clk);
    rd(STATUS_ADDR, 32'h00000101, 32'h00000101, RESP_OKAY);
    check("reset pulses", 32'(n_irst - k), 32'h00000000);
    main_half <= 8'h0A;
    repeat (300) @(posedge ref_clk);
    pin_clear;
    rd(STATUS_ADDR, 32'h00000101, 32'h00000000, RESP_OKAY);
    main_run <= 1'b0;
    repeat (400) @(posedge ref_clk);
    rd(STATUS_ADDR, 32'h00000106, 32'h00000106, RESP_OKAY);
    check("reset pulse seen", 32'(n_irst > k), 32'h00000001);
    main_run <= 1'b1;
    repeat (300) @(posedge ref_clk);
    pin_clear;
    rd(STATUS_ADDR, 32'h0000010F, 32'h00000000, RESP_OKAY);
    report_and_stop;
  end
endmodule
